/* File: verilog/vrd_pkg.sv */
// package: port map, field positions and encodings of the video register decode
package vrd_pkg;
  localparam logic [15:0] P_ATTR_IDX = 16'h03c0;
  localparam logic [15:0] P_ATTR_RD = 16'h03c1;
  localparam logic [15:0] P_GEN_WR = 16'h03c2;
  localparam logic [15:0] P_SUBSYS = 16'h03c3;
  localparam logic [15:0] P_SEQ_IDX = 16'h03c4;
  localparam logic [15:0] P_SEQ_DATA = 16'h03c5;
  localparam logic [15:0] P_PIX_MASK = 16'h03c6;
  localparam logic [15:0] P_PAL_RIDX = 16'h03c7;
  localparam logic [15:0] P_PAL_WIDX = 16'h03c8;
  localparam logic [15:0] P_PAL_DATA = 16'h03c9;
  localparam logic [15:0] P_FEAT_RD = 16'h03ca;
  localparam logic [15:0] P_GEN_RD = 16'h03cc;
  localparam logic [15:0] P_GFX_IDX = 16'h03ce;
  localparam logic [15:0] P_GFX_DATA = 16'h03cf;
  localparam logic [15:0] P_MONO_BASE = 16'h03b0;
  localparam logic [15:0] P_COLR_BASE = 16'h03d0;
  localparam logic [3:0] P_CRT_IDX_LO = 4'h4;
  localparam logic [3:0] P_CRT_DATA_LO = 4'h5;
  localparam logic [3:0] P_STAT1_LO = 4'ha;
  localparam logic [19:0] MEM_BASE = 20'ha0000;
  localparam logic [19:0] MEM_SPAN = 20'h10000;
  localparam logic [15:0] LINEAR_BYTES = 16'hfa00;
  // general output fields
  localparam int GO_VSP = 7;
  localparam int GO_HSP = 6;
  localparam int GO_PAGE = 5;
  localparam int GO_CS_HI = 3;
  localparam int GO_CS_LO = 2;
  localparam int GO_BUF_EN = 1;
  localparam int GO_IOSEL = 0;
  localparam logic [7:0] GO_WMASK = 8'hef;
  localparam logic [1:0] VS_400 = 2'h1;
  localparam logic [1:0] VS_350 = 2'h2;
  localparam logic [1:0] VS_480 = 2'h3;
  localparam logic [1:0] CS_25M = 2'h0;
  localparam logic [1:0] CS_28M = 2'h1;
  localparam logic [2:0] SEQ_MAP_MASK = 3'h2;
  localparam int SEQ_REGS = 5;
  localparam int GFX_REGS = 9;
  localparam int CRT_REGS = 25;
  localparam int ATTR_REGS = 21;
  localparam int PAL_WORDS = 3;
  localparam logic [5:0] PAL_CH_MASK = 6'h3f;
  typedef enum logic [1:0] {
    VRD_MODE_MONO2,
    VRD_MODE_PLANAR16,
    VRD_MODE_LINEAR256,
    VRD_MODE_TEXT
  } vrd_mode_t;
endpackage

/* File: verilog/vrd_top.sv */
// video register decode: host i/o ports, display-memory decode and scan-out fetch
`timescale 1ns/100ps
module vrd_top #(
  parameter int MEM_AW = 16
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // host i/o cycles
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_ACK,
  // host memory cycles
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA,
  output logic MEM_ACK,
  // status inputs from the display timing (asynchronous)
  input wire logic VRETRACE,
  input wire logic DISP_INACTIVE,
  input wire logic [3:0] SENSE_SW,
  // scan-out request and pixel outputs
  input wire logic SCAN_REQ,
  input wire logic [15:0] SCAN_ADDR,
  input wire logic [8:0] SCAN_LINE,
  input wire vrd_pkg::vrd_mode_t SCAN_MODE,
  output logic [7:0] PIXEL_INDEX,
  output logic PIXEL_VALID,
  output logic [15:0] ROW_ADDR,
  // configuration outputs
  output logic VSYNC_NEG,
  output logic HSYNC_NEG,
  output logic [1:0] VSIZE_SEL,
  output logic [1:0] CLOCK_SEL,
  output logic VSIZE_BAD,
  output logic CLOCK_BAD
);
  import vrd_pkg::*;

  initial begin
    if (MEM_AW < 16 || MEM_AW > 20) $error("vrd_top: MEM_AW out of range");
  end

  localparam int DEPTH = 1 << MEM_AW;

  typedef struct packed {
    logic vsize_bad;
    logic [1:0] vr_s;
    logic [1:0] de_s;
    logic [7:0] sw_s;
    logic [7:0] gen_out;
    logic [7:0] subsys;
    logic [7:0] feature;
    logic [2:0] seq_idx;
    logic [3:0] gfx_idx;
    logic [4:0] crt_idx;
    logic [4:0] attr_idx;
    logic attr_toggle;
    logic [7:0] pix_mask;
    logic [7:0] pal_widx;
    logic [7:0] pal_ridx;
    logic [1:0] pal_wsub;
    logic [1:0] pal_rsub;
    logic [11:0] pal_hold;
    logic [7:0] io_rdata;
    logic io_ack;
    logic [7:0] mem_rdata;
    logic mem_ack;
    logic [7:0] pixel;
    logic pix_valid;
    logic [15:0] row_addr;
  } vrd_state_t;

  vrd_state_t s_r, s_nxt;
  logic [7:0] seq_regs [SEQ_REGS];
  logic [7:0] gfx_regs [GFX_REGS];
  logic [7:0] crt_regs [CRT_REGS];
  logic [7:0] attr_regs [ATTR_REGS];
  logic [17:0] pal_ram [256];
  logic [7:0] plane [4][DEPTH];
  // reset synchroniser sits apart: it runs on the raw pin, the struct on its copy
  logic [1:0] rst_sync_r;
  logic rst_b_int;
  assign rst_b_int = rst_sync_r[1];

  // port decode, relocated crt and status ports
  logic [15:0] rng_base;
  logic hit_crt_idx, hit_crt_data, hit_stat1;
  logic [17:0] pal_rd_word;
  assign rng_base = s_r.gen_out[GO_IOSEL] ? P_COLR_BASE : P_MONO_BASE;
  assign hit_crt_idx = IO_ADDR == (rng_base | {12'h000, P_CRT_IDX_LO});
  assign hit_crt_data = IO_ADDR == (rng_base | {12'h000, P_CRT_DATA_LO});
  assign hit_stat1 = IO_ADDR == (rng_base | {12'h000, P_STAT1_LO});
  assign pal_rd_word = pal_ram[s_r.pal_ridx];

  // memory decode
  logic mem_hit;
  logic [19:0] mem_off;
  logic [MEM_AW-1:0] mem_a;
  assign mem_off = MEM_ADDR - MEM_BASE;
  assign mem_hit = s_r.gen_out[GO_BUF_EN] && MEM_ADDR >= MEM_BASE &&
                   mem_off < MEM_SPAN;
  // page bit selects upper 64K in even/odd text
  assign mem_a = (SCAN_MODE == VRD_MODE_TEXT && MEM_AW > 16) ?
                 MEM_AW'({s_r.gen_out[GO_PAGE], mem_off[15:0]}) : MEM_AW'(mem_off[15:0]);

  // scan-out fetch
  logic [MEM_AW-1:0] scan_a, lin_a;
  logic [7:0] b0, b1, b2, b3, lin_byte;
  assign scan_a = MEM_AW'(SCAN_ADDR);
  // linear byte n lives in plane n%4 at n/4
  assign lin_a = MEM_AW'(SCAN_ADDR[15:2]);
  assign b0 = plane[0][scan_a];
  assign b1 = plane[1][scan_a];
  assign b2 = plane[2][scan_a];
  assign b3 = plane[3][scan_a];
  // one plane sample forms the 8-bit index
  assign lin_byte = plane[SCAN_ADDR[1:0]][lin_a];

  always_comb begin
    s_nxt = s_r;
    s_nxt.vr_s = {s_r.vr_s[0], VRETRACE};
    s_nxt.de_s = {s_r.de_s[0], DISP_INACTIVE};
    s_nxt.sw_s = {s_r.sw_s[3:0], SENSE_SW};
    s_nxt.io_ack = IO_WR | IO_RD;
    s_nxt.io_rdata = 8'h00;
    s_nxt.mem_ack = (MEM_WR | MEM_RD) & mem_hit;
    s_nxt.mem_rdata = 8'h00;
    s_nxt.pix_valid = SCAN_REQ;
    if (IO_WR) begin
      if (IO_ADDR == P_GEN_WR) s_nxt.gen_out = IO_WDATA & GO_WMASK;
      if (IO_ADDR == P_SUBSYS) s_nxt.subsys = IO_WDATA;
      if (hit_stat1) s_nxt.feature = IO_WDATA;
      if (IO_ADDR == P_SEQ_IDX) s_nxt.seq_idx = IO_WDATA[2:0];
      if (IO_ADDR == P_GFX_IDX) s_nxt.gfx_idx = IO_WDATA[3:0];
      if (hit_crt_idx) s_nxt.crt_idx = IO_WDATA[4:0];
      if (IO_ADDR == P_ATTR_IDX) begin
        s_nxt.attr_toggle = ~s_r.attr_toggle;
        if (!s_r.attr_toggle) s_nxt.attr_idx = IO_WDATA[4:0];
      end
      if (IO_ADDR == P_PIX_MASK) s_nxt.pix_mask = IO_WDATA;
      if (IO_ADDR == P_PAL_WIDX) begin
        s_nxt.pal_widx = IO_WDATA;
        s_nxt.pal_wsub = 2'h0;
      end
      if (IO_ADDR == P_PAL_RIDX) begin
        s_nxt.pal_ridx = IO_WDATA;
        s_nxt.pal_rsub = 2'h0;
      end
      if (IO_ADDR == P_PAL_DATA) begin
        // three 6-bit writes build one entry
        if (s_r.pal_wsub == 2'(PAL_WORDS - 1)) begin
          s_nxt.pal_wsub = 2'h0;
          s_nxt.pal_widx = s_r.pal_widx + 8'h01;
        end else begin
          s_nxt.pal_wsub = s_r.pal_wsub + 2'h1;
          s_nxt.pal_hold = {s_r.pal_hold[5:0], IO_WDATA[5:0]};
        end
      end
    end
    if (IO_RD) begin
      if (IO_ADDR == P_GEN_RD) s_nxt.io_rdata = s_r.gen_out;
      else if (IO_ADDR == P_GEN_WR)
        s_nxt.io_rdata = {s_r.vr_s[1], 2'h0, (s_r.sw_s[7:4] != 4'h0), 4'h0};
      else if (IO_ADDR == P_SUBSYS) s_nxt.io_rdata = s_r.subsys;
      else if (IO_ADDR == P_FEAT_RD) s_nxt.io_rdata = s_r.feature;
      else if (hit_stat1) begin
        s_nxt.io_rdata = {4'h0, s_r.vr_s[1], 2'h0, s_r.de_s[1]};
        s_nxt.attr_toggle = 1'b0;
      end
      else if (IO_ADDR == P_SEQ_IDX) s_nxt.io_rdata = {5'h00, s_r.seq_idx};
      else if (IO_ADDR == P_SEQ_DATA && 32'(s_r.seq_idx) < SEQ_REGS)
        s_nxt.io_rdata = seq_regs[s_r.seq_idx];
      else if (IO_ADDR == P_GFX_IDX) s_nxt.io_rdata = {4'h0, s_r.gfx_idx};
      else if (IO_ADDR == P_GFX_DATA && 32'(s_r.gfx_idx) < GFX_REGS)
        s_nxt.io_rdata = gfx_regs[s_r.gfx_idx];
      else if (hit_crt_idx) s_nxt.io_rdata = {3'h0, s_r.crt_idx};
      else if (hit_crt_data && 32'(s_r.crt_idx) < CRT_REGS)
        s_nxt.io_rdata = crt_regs[s_r.crt_idx];
      else if (IO_ADDR == P_ATTR_IDX) s_nxt.io_rdata = {3'h0, s_r.attr_idx};
      else if (IO_ADDR == P_ATTR_RD && 32'(s_r.attr_idx) < ATTR_REGS)
        s_nxt.io_rdata = attr_regs[s_r.attr_idx];
      else if (IO_ADDR == P_PIX_MASK) s_nxt.io_rdata = s_r.pix_mask;
      else if (IO_ADDR == P_PAL_WIDX) s_nxt.io_rdata = s_r.pal_widx;
      else if (IO_ADDR == P_PAL_DATA) begin
        case (s_r.pal_rsub)
          2'h0: s_nxt.io_rdata = {2'h0, pal_rd_word[17:12]};
          2'h1: s_nxt.io_rdata = {2'h0, pal_rd_word[11:6]};
          default: s_nxt.io_rdata = {2'h0, pal_rd_word[5:0]};
        endcase
        if (s_r.pal_rsub == 2'(PAL_WORDS - 1)) begin
          s_nxt.pal_rsub = 2'h0;
          s_nxt.pal_ridx = s_r.pal_ridx + 8'h01;
        end else begin
          s_nxt.pal_rsub = s_r.pal_rsub + 2'h1;
        end
      end
    end
    if (MEM_RD && mem_hit) s_nxt.mem_rdata = plane[seq_regs[SEQ_MAP_MASK][1] ? 1 : 0][mem_a];
    if (SCAN_REQ) begin
      case (SCAN_MODE)
        // plane 0 only, whole byte passed as the pixel index
        VRD_MODE_MONO2: s_nxt.pixel = b0;
        VRD_MODE_PLANAR16: s_nxt.pixel = {4'h0, b3[7], b2[7], b1[7], b0[7]};
        VRD_MODE_LINEAR256:
          s_nxt.pixel = (SCAN_ADDR < LINEAR_BYTES) ? lin_byte & s_r.pix_mask : 8'h00;
        default: s_nxt.pixel = b0;
      endcase
      // in linear 256 mode each stored row serves two lines; other modes pass SCAN_ADDR
      s_nxt.row_addr = (SCAN_MODE == VRD_MODE_LINEAR256) ?
                       16'({7'h00, SCAN_LINE[8:1]} * 16'd320) : SCAN_ADDR;
    end
    s_nxt.vsize_bad = s_nxt.gen_out[GO_VSP:GO_HSP] == 2'h0;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge CLK or negedge rst_b_int) begin
    if (!rst_b_int) begin
      s_r <= '0;
      // cleared general output is the reserved size code
      s_r.vsize_bad <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // register arrays and memories, written on host cycles
  always_ff @(posedge CLK) begin
    if (IO_WR && IO_ADDR == P_SEQ_DATA && 32'(s_r.seq_idx) < SEQ_REGS)
      seq_regs[s_r.seq_idx] <= IO_WDATA;
    if (IO_WR && IO_ADDR == P_GFX_DATA && 32'(s_r.gfx_idx) < GFX_REGS)
      gfx_regs[s_r.gfx_idx] <= IO_WDATA;
    if (IO_WR && hit_crt_data && 32'(s_r.crt_idx) < CRT_REGS)
      crt_regs[s_r.crt_idx] <= IO_WDATA;
    if (IO_WR && IO_ADDR == P_ATTR_IDX && s_r.attr_toggle && 32'(s_r.attr_idx) < ATTR_REGS)
      attr_regs[s_r.attr_idx] <= IO_WDATA;
    if (IO_WR && IO_ADDR == P_PAL_DATA && s_r.pal_wsub == 2'(PAL_WORDS - 1))
      pal_ram[s_r.pal_widx] <= {s_r.pal_hold, IO_WDATA[5:0]} & {3{PAL_CH_MASK}};
    for (int p = 0; p < 4; p++) begin
      if (MEM_WR && mem_hit && seq_regs[SEQ_MAP_MASK][p]) plane[p][mem_a] <= MEM_WDATA;
    end
  end

  assign IO_RDATA = s_r.io_rdata;
  assign IO_ACK = s_r.io_ack;
  assign MEM_RDATA = s_r.mem_rdata;
  assign MEM_ACK = s_r.mem_ack;
  assign PIXEL_INDEX = s_r.pixel;
  assign PIXEL_VALID = s_r.pix_valid;
  assign ROW_ADDR = s_r.row_addr;
  assign VSYNC_NEG = s_r.gen_out[GO_VSP];
  assign HSYNC_NEG = s_r.gen_out[GO_HSP];
  assign VSIZE_SEL = {s_r.gen_out[GO_VSP], s_r.gen_out[GO_HSP]};
  assign VSIZE_BAD = s_r.vsize_bad;
  assign CLOCK_SEL = s_r.gen_out[GO_CS_HI:GO_CS_LO];
  assign CLOCK_BAD = CLOCK_SEL[1];
endmodule // vrd_top

/* File: test/vrd_top_assertions.sv */
// port checker for the video register decode
`timescale 1ns/100ps
module vrd_top_assertions
  import vrd_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // host cycles
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_ACK,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic [19:0] MEM_ADDR,
  input wire logic MEM_ACK,
  // scan-out
  input wire logic SCAN_REQ,
  input wire logic [8:0] SCAN_LINE,
  input wire vrd_pkg::vrd_mode_t SCAN_MODE,
  input wire logic PIXEL_VALID,
  input wire logic [15:0] ROW_ADDR,
  // configuration
  input wire logic VSYNC_NEG,
  input wire logic HSYNC_NEG,
  input wire logic [1:0] VSIZE_SEL,
  input wire logic [1:0] CLOCK_SEL,
  input wire logic VSIZE_BAD,
  input wire logic CLOCK_BAD
);
  import vrd_pkg::*;
  logic io_req, gen_wr, mem_hit, buf_en_r;
  logic [7:0] wd_r;
  assign io_req = IO_WR || IO_RD;
  assign gen_wr = IO_WR && IO_ADDR == P_GEN_WR;
  // mirror of the enable bit; a hit needs it and the 64K window
  assign mem_hit = (MEM_WR || MEM_RD) && buf_en_r && MEM_ADDR >= MEM_BASE
    && MEM_ADDR < MEM_BASE + MEM_SPAN;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      buf_en_r <= 1'b0;
      wd_r <= 8'h00;
    end else begin
      wd_r <= IO_WDATA;
      if (gen_wr) buf_en_r <= IO_WDATA[GO_BUF_EN];
    end
  end
  default clocking dclk @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  chk_io_answer: assert property (io_req |=> IO_ACK)
    else $error("io cycle not answered");
  chk_ack_cause: assert property (IO_ACK |-> $past(io_req))
    else $error("stray io ack");
  chk_vsync_bit: assert property (gen_wr |=> VSYNC_NEG == wd_r[GO_VSP])
    else $error("vsync polarity wrong");
  chk_hsync_bit: assert property (gen_wr |=> HSYNC_NEG == wd_r[GO_HSP])
    else $error("hsync polarity wrong");
  chk_vsize_pair: assert property (
    VSIZE_SEL == {VSYNC_NEG, HSYNC_NEG} && VSIZE_BAD == (VSIZE_SEL == 2'h0))
    else $error("vertical size wrong");
  chk_clock_field: assert property (gen_wr |=>
    CLOCK_SEL == wd_r[GO_CS_HI:GO_CS_LO] && CLOCK_BAD == wd_r[GO_CS_HI])
    else $error("clock select wrong");
  chk_cfg_hold: assert property (!gen_wr |=> $stable(CLOCK_SEL) && $stable(VSIZE_SEL))
    else $error("config changed unasked");
  chk_mem_decode: assert property (MEM_ACK == $past(mem_hit))
    else $error("buffer decode wrong");
  chk_row_double: assert property ((SCAN_REQ && SCAN_MODE == VRD_MODE_LINEAR256) |=>
    ROW_ADDR == ($past(SCAN_LINE) >> 1) * 16'd320)
    else $error("row address wrong");
  chk_pixel_pulse: assert property (PIXEL_VALID == $past(SCAN_REQ))
    else $error("pixel valid wrong");
  cov_gen_write: cover property (gen_wr ##1 IO_ACK);
  cov_mem_hit: cover property (mem_hit ##1 MEM_ACK);
  cov_scan_row: cover property (SCAN_REQ && SCAN_MODE == VRD_MODE_LINEAR256);
endmodule // vrd_top_assertions

bind vrd_top vrd_top_assertions vrd_top_assertions_i (.*);

/* File: test/vrd_host_model.sv */
// host processor model issuing io and memory cycles
`timescale 1ns/100ps
module vrd_host_model (
  // clock
  input wire logic CLK,
  // io cycles
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack,
  // memory cycles
  output logic mem_wr,
  output logic mem_rd,
  output logic [19:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  initial begin
    {io_wr, io_rd, io_addr, io_wdata, mem_wr, mem_rd, mem_addr, mem_wdata} = '0;
  end
  // random idle gaps model a slow host; strobe lasts one cycle
  task automatic cyc(input bit m, input bit w, input logic [19:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ack);
    repeat ($urandom_range(0, 2)) @(posedge CLK);
    @(posedge CLK);
    if (m) {mem_wr, mem_rd, mem_addr, mem_wdata} <= {w, !w, a, d};
    else {io_wr, io_rd, io_addr, io_wdata} <= {w, !w, a[15:0], d};
    @(posedge CLK);
    {io_wr, io_rd, mem_wr, mem_rd} <= 4'h0;
    // released lines carry a changing pattern, not the last value
    {io_addr, io_wdata, mem_addr, mem_wdata} <= 52'({$urandom, $urandom});
    #1;
    q = m ? mem_rdata : io_rdata;
    ack = m ? mem_ack : io_ack;
  endtask
endmodule // vrd_host_model

/* File: test/video_register_decode_bench.sv */
// self-checking bench for the video register decode
`timescale 1ns/100ps
module video_register_decode_bench;
  import vrd_pkg::*;
  logic CLK, RST_B, IO_WR, IO_RD, IO_ACK, MEM_WR, MEM_RD, MEM_ACK, VRETRACE, DISP_INACTIVE;
  logic SCAN_REQ, PIXEL_VALID, VSYNC_NEG, HSYNC_NEG, VSIZE_BAD, CLOCK_BAD, ack;
  logic [1:0] VSIZE_SEL, CLOCK_SEL;
  logic [3:0] SENSE_SW, msk;
  logic [7:0] IO_WDATA, IO_RDATA, MEM_WDATA, MEM_RDATA, PIXEL_INDEX, q, v, gen, pm;
  logic [8:0] SCAN_LINE;
  logic [15:0] IO_ADDR, SCAN_ADDR, ROW_ADDR, b, alt;
  logic [19:0] MEM_ADDR;
  vrd_mode_t SCAN_MODE;
  int err_count, check_count, k, p, off, ln;
  int pl[4];
  int pal[$];
  vrd_top vrd_top_i (.*);
  vrd_host_model vrd_host_model_i (.CLK(CLK), .io_wr(IO_WR), .io_rd(IO_RD), .io_addr(IO_ADDR),
    .io_wdata(IO_WDATA), .io_rdata(IO_RDATA), .io_ack(IO_ACK), .mem_wr(MEM_WR), .mem_rd(MEM_RD),
    .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_rdata(MEM_RDATA), .mem_ack(MEM_ACK));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    vrd_host_model_i.cyc(1'b0, 1'b1, {4'h0, a}, d, q, ack);
  endtask
  task automatic rd(input logic [15:0] a);
    vrd_host_model_i.cyc(1'b0, 1'b0, {4'h0, a}, 8'h00, q, ack);
  endtask
  task automatic mem(input bit w, input logic [19:0] a, input logic [7:0] d);
    vrd_host_model_i.cyc(1'b1, w, a, d, q, ack);
  endtask
  task automatic gen_set(input logic [7:0] nv);
    rd(P_GEN_RD);
    gen = nv & GO_WMASK;
    wr(P_GEN_WR, (q & ~GO_WMASK) | gen);
  endtask
  task automatic scan(input logic [15:0] a, input logic [8:0] l);
    @(posedge CLK);
    SCAN_REQ <= 1'b1;
    SCAN_ADDR <= a;
    SCAN_LINE <= l;
    @(posedge CLK);
    SCAN_REQ <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    give_verdict();
  end
  initial begin
    {RST_B, VRETRACE, DISP_INACTIVE, SENSE_SW, SCAN_REQ, SCAN_ADDR, SCAN_LINE} = '0;
    SCAN_MODE = VRD_MODE_LINEAR256;
    err_count = 0;
    check_count = 0;
    void'($urandom(32'hb7a1));
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge CLK);
    rd(P_GEN_RD);
    chk(q, 8'h00, "gen reset");
    chk(VSIZE_BAD, 1'b1, "reset size reserved");
    for (k = 0; k < 6; k++) begin
      v = 8'($urandom);
      v[7] = v[7] | ~v[6];
      v[3] = 1'b0;
      gen_set(v);
      rd(P_GEN_RD);
      chk(q, gen, "gen readback");
      chk(VSYNC_NEG, gen[GO_VSP], "vsync");
      chk(HSYNC_NEG, gen[GO_HSP], "hsync");
      chk({VSIZE_BAD, VSIZE_SEL}, {1'b0, gen[7:6]}, "vsize");
      chk({CLOCK_BAD, CLOCK_SEL}, {1'b0, gen[3:2]}, "clock");
    end
    $display("general output test done");
    for (k = 0; k < 2; k++) begin
      gen_set(gen & 8'hfe | 8'(k));
      b = k ? P_COLR_BASE : P_MONO_BASE;
      alt = k ? P_MONO_BASE : P_COLR_BASE;
      v = 8'($urandom);
      wr(b | 16'(P_CRT_IDX_LO), 8'h0c);
      wr(b | 16'(P_CRT_DATA_LO), v);
      rd(b | 16'(P_CRT_DATA_LO));
      chk(q, v, "crt data");
      rd(b | 16'(P_CRT_IDX_LO));
      chk(q, 8'h0c, "crt index");
      rd(alt | 16'(P_CRT_IDX_LO));
      chk(q, 8'h00, "crt other range");
      wr(b | 16'(P_STAT1_LO), v);
      rd(P_FEAT_RD);
      chk(q, v, "feature write");
      VRETRACE <= k[0];
      DISP_INACTIVE <= !k[0];
      SENSE_SW <= k ? 4'h4 : 4'h0;
      repeat (3) @(posedge CLK);
      rd(b | 16'(P_STAT1_LO));
      chk(q, {4'h0, k[0], 2'b00, !k[0]}, "status one");
      rd(P_GEN_WR);
      chk(q, {k[0], 2'b00, k[0], 4'h0}, "status zero");
    end
    for (k = 0; k < 4; k++) begin
      b = k == 0 ? P_SUBSYS : k == 1 ? P_SEQ_IDX : k == 2 ? P_PAL_WIDX : P_PIX_MASK;
      v = k == 1 ? 8'h02 : 8'($urandom);
      wr(b, v);
      rd(b);
      chk(q, v, "register readback");
    end
    pm = v;
    wr(P_PAL_WIDX, 8'h21);
    for (k = 0; k < 3; k++) begin
      v = 8'($urandom);
      pal.push_back(v & PAL_CH_MASK);
      wr(P_PAL_DATA, v);
    end
    rd(P_PAL_WIDX);
    chk(q, 8'h22, "write index step");
    wr(P_PAL_RIDX, 8'h21);
    for (k = 0; k < 3; k++) begin
      rd(P_PAL_DATA);
      chk(q, 16'(pal.pop_front()), "palette colour");
    end
    $display("port map test done");
    wr(P_SEQ_IDX, {5'h00, SEQ_MAP_MASK});
    gen_set(gen & 8'hfd);
    mem(1'b1, MEM_BASE, 8'h55);
    chk(ack, 1'b0, "decode off");
    gen_set(gen | 8'h02);
    mem(1'b1, MEM_BASE + MEM_SPAN, 8'h55);
    chk(ack, 1'b0, "outside window");
    for (k = 0; k < 4; k++) begin
      off = k == 0 ? 15999 : $urandom_range(0, 15999);
      v = 8'($urandom);
      wr(P_SEQ_DATA, 8'h0f);
      mem(1'b1, MEM_BASE + 20'(off), v);
      mem(1'b0, MEM_BASE + 20'(off), 8'h00);
      chk({ack, q}, {1'b1, v}, "buffer read");
      pl = '{v, v, v, v};
      msk = 4'($urandom);
      v = 8'($urandom);
      wr(P_SEQ_DATA, {4'h0, msk});
      mem(1'b1, MEM_BASE + 20'(off), v);
      for (p = 0; p < 4; p++) begin
        if (msk[p]) pl[p] = v;
        ln = $urandom_range(0, 399);
        scan(16'(4 * off + p), 9'(ln));
        chk(PIXEL_INDEX, 16'(pl[p]) & pm, "linear pixel");
        chk(ROW_ADDR, 16'(ln / 2 * 320), "row address");
      end
    end
    SCAN_MODE <= VRD_MODE_MONO2;
    scan(16'(off), 9'h000);
    chk(PIXEL_INDEX, 16'(pl[0]), "mono pixel");
    SCAN_MODE <= VRD_MODE_PLANAR16;
    scan(16'(off), 9'h000);
    chk(PIXEL_INDEX, {12'h000, pl[3][7], pl[2][7], pl[1][7], pl[0][7]}, "planar pixel");
    $display("memory and scan-out test done");
    give_verdict();
  end
endmodule // video_register_decode_bench
